//--- verilog/rtcu_core.sv
// clock core: time base, update cycle, control and flag bytes, index/data access
// assumes bus strobes and pins synchronous to clk; rst_b is the power-up of the clock well
`default_nettype none
`include "rtcu_params.svh"
module rtcu_core #(
  parameter int unsigned CLK_HZ = `RTCU_CLK_HZ,
  parameter int unsigned TB_HZ = `RTCU_TB_HZ
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic primary_reset_b,
  input wire logic battery_sense_input,
  input wire logic bus_data_sel,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire rtcu_pkg::rtcu_byte_t bus_wdata,
  output rtcu_pkg::rtcu_byte_t bus_rdata,
  output logic irq
);
  localparam int unsigned CW = `RTCU_CHAIN_W;
  // durations in nominal base ticks; TB_HZ only sets how often a tick comes
  localparam int unsigned UPD_TICKS = (`RTCU_UPD_US * `RTCU_TB_HZ) / 1000000;
  localparam int unsigned LEAD_TICKS = (`RTCU_LEAD_US * `RTCU_TB_HZ + 999999) / 1000000;
  localparam int unsigned START_TICKS = (`RTCU_START_MS * `RTCU_TB_HZ) / 1000;
  localparam logic [CW-1:0] PEND_AT = CW'((1 << CW) - LEAD_TICKS);
  localparam logic [6:0] UPD_LAST = 7'(UPD_TICKS - 1);
  localparam logic [31:0] TB_INC = 32'(TB_HZ);
  localparam logic [31:0] CLK_MOD = 32'(CLK_HZ);

  initial
  begin
    if (TB_HZ == 0 || TB_HZ > CLK_HZ || UPD_TICKS < 1 || UPD_TICKS > 127 || START_TICKS >= (1 << CW))
      $error("rtcu_core: clock rates cannot serve the time base");
  end

  logic [31:0] acc_r;
  logic [2:0] osc_ctrl_r;
  logic [3:0] rate_sel_r;
  rtcu_pkg::rtcu_byte_t ctl_b_r;
  rtcu_pkg::rtcu_byte_t ram_r [`RTCU_NUM_BYTES];
  logic [6:0] idx_r;
  logic [6:0] upd_cnt_r;
  logic uf_r;
  logic summary_irq_flag_r;
  logic vrt_r;
  logic mrst_d_r;
  rtcu_pkg::rtcu_upd_e upd_r;
  rtcu_pkg::rtcu_upd_e upd_nxt;
  logic [CW-1:0] chain_cnt;
  logic chain_wrap;
  logic osc_run;
  logic osc_hold;
  logic osc_on;
  logic tb_tick;
  logic logic_clr;
  logic upd_done;
  logic inhibit;
  logic update_in_progress_flag;
  logic data_wr;
  logic data_rd;
  logic time_idx;
  rtcu_pkg::rtcu_byte_t sec_nxt;
  rtcu_pkg::rtcu_byte_t min_nxt;
  rtcu_pkg::rtcu_byte_t hour_nxt;
  logic sec_carry;
  logic min_carry;

  assign osc_run = osc_ctrl_r == `RTCU_OSC_NORMAL;
  assign osc_hold = osc_ctrl_r[2:1] == 2'b11;
  assign osc_on = osc_run || osc_hold;
  assign tb_tick = osc_on && (acc_r + TB_INC >= CLK_MOD);
  assign inhibit = ctl_b_r[`RTCU_B_SET] || !osc_run || logic_clr;
  assign update_in_progress_flag = upd_r != rtcu_pkg::UPD_IDLE;
  assign data_wr = bus_wr && bus_data_sel;
  assign data_rd = bus_rd && bus_data_sel;
  assign time_idx = idx_r < `RTCU_NUM_TIME;
  assign irq = summary_irq_flag_r;

  // fractional divider from the system clock to the 32768 Hz base
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      acc_r <= '0;
    else if (tb_tick)
      acc_r <= acc_r + TB_INC - CLK_MOD;
    else if (osc_on)
      acc_r <= acc_r + TB_INC;
  end

  rtcu_chain #(
    .WIDTH(CW),
    .PRELOAD((1 << CW) - START_TICKS)
  ) u_chain (
    .clk(clk),
    .rst_b(rst_b),
    .clr(logic_clr),
    .hold(osc_hold),
    .adv(tb_tick && osc_run),
    .count(chain_cnt),
    .wrap(chain_wrap)
  );

  // battery check at master reset release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mrst_d_r <= 1'b0;
    else
      mrst_d_r <= primary_reset_b;
  end
  assign logic_clr = primary_reset_b && !mrst_d_r && !battery_sense_input;

  // oscillator code survives the clock-logic reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      osc_ctrl_r <= `RTCU_OSC_RESET;
    else if (data_wr && idx_r == `RTCU_IDX_A)
      osc_ctrl_r <= bus_wdata[`RTCU_A_OSC_HI:`RTCU_A_OSC_LO];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rate_sel_r <= '0;
      ctl_b_r <= '0;
    end
    else if (logic_clr)
    begin
      rate_sel_r <= '0;
      ctl_b_r <= '0;
    end
    else if (data_wr && idx_r == `RTCU_IDX_A)
      rate_sel_r <= bus_wdata[3:0];
    else if (data_wr && idx_r == `RTCU_IDX_B)
      ctl_b_r <= bus_wdata;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      idx_r <= '0;
    else if (bus_wr && !bus_data_sel)
      idx_r <= bus_wdata[6:0];
  end

  // update sequencer
  always_comb
  begin
    upd_nxt = upd_r;
    unique case (upd_r)
      rtcu_pkg::UPD_IDLE:
        if (chain_cnt >= PEND_AT)
          upd_nxt = rtcu_pkg::UPD_PEND;
      rtcu_pkg::UPD_PEND:
        if (chain_wrap)
          upd_nxt = rtcu_pkg::UPD_BUSY;
      rtcu_pkg::UPD_BUSY:
        if (tb_tick && upd_cnt_r == UPD_LAST)
          upd_nxt = rtcu_pkg::UPD_IDLE;
    endcase
    if (inhibit)
      upd_nxt = rtcu_pkg::UPD_IDLE;
  end
  assign upd_done = !inhibit && upd_r == rtcu_pkg::UPD_BUSY && tb_tick && upd_cnt_r == UPD_LAST;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      upd_r <= rtcu_pkg::UPD_IDLE;
    else
      upd_r <= upd_nxt;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      upd_cnt_r <= '0;
    else if (upd_r != rtcu_pkg::UPD_BUSY)
      upd_cnt_r <= '0;
    else if (tb_tick)
      upd_cnt_r <= upd_cnt_r + 7'h01;
  end

  // time fields step in the selected format
  rtcu_incr #(.LIMIT(59)) u_sec (
    .value_in(ram_r[`RTCU_IDX_SEC]),
    .bcd_mode(!ctl_b_r[`RTCU_B_DM]),
    .value_out(sec_nxt),
    .carry(sec_carry)
  );
  rtcu_incr #(.LIMIT(59)) u_min (
    .value_in(ram_r[`RTCU_IDX_MIN]),
    .bcd_mode(!ctl_b_r[`RTCU_B_DM]),
    .value_out(min_nxt),
    .carry(min_carry)
  );
  rtcu_incr #(.LIMIT(23)) u_hour (
    .value_in(ram_r[`RTCU_IDX_HOUR]),
    .bcd_mode(!ctl_b_r[`RTCU_B_DM]),
    .value_out(hour_nxt),
    .carry()
  );

  // byte store; master reset clears it only with a low battery
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < `RTCU_NUM_BYTES; i++)
        ram_r[i] <= '0;
    end
    else if (logic_clr)
    begin
      for (int i = 0; i < `RTCU_NUM_BYTES; i++)
        ram_r[i] <= '0;
    end
    else if (upd_done)
    begin
      ram_r[`RTCU_IDX_SEC] <= sec_nxt;
      if (sec_carry)
        ram_r[`RTCU_IDX_MIN] <= min_nxt;
      if (sec_carry && min_carry)
        ram_r[`RTCU_IDX_HOUR] <= hour_nxt;
    end
    else if (data_wr && !(time_idx && update_in_progress_flag) && (idx_r < `RTCU_IDX_A || idx_r > `RTCU_IDX_D))
      ram_r[idx_r] <= bus_wdata;
  end

  // update-ended and summary flags, read of index 0ch clears, set wins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      uf_r <= 1'b0;
      summary_irq_flag_r <= 1'b0;
    end
    else if (logic_clr)
    begin
      uf_r <= 1'b0;
      summary_irq_flag_r <= 1'b0;
    end
    else if (upd_done)
    begin
      uf_r <= 1'b1;
      summary_irq_flag_r <= ctl_b_r[`RTCU_B_UIE] | (summary_irq_flag_r & !(data_rd && idx_r == `RTCU_IDX_C));
    end
    else if (data_rd && idx_r == `RTCU_IDX_C)
    begin
      uf_r <= 1'b0;
      summary_irq_flag_r <= 1'b0;
    end
  end

  // valid flag: cleared by low battery, reads one once read
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      vrt_r <= 1'b0;
    else if (logic_clr)
      vrt_r <= 1'b0;
    else if (data_rd && idx_r == `RTCU_IDX_D)
      vrt_r <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bus_rdata <= '0;
    else if (bus_rd && !bus_data_sel)
      bus_rdata <= {1'b0, idx_r};
    else if (data_rd)
    begin
      if (time_idx && upd_r == rtcu_pkg::UPD_BUSY)
        bus_rdata <= `RTCU_UNDEF_BYTE;
      else if (idx_r == `RTCU_IDX_A)
        bus_rdata <= {update_in_progress_flag, osc_ctrl_r, rate_sel_r};
      else if (idx_r == `RTCU_IDX_B)
        bus_rdata <= ctl_b_r;
      else if (idx_r == `RTCU_IDX_C)
        bus_rdata <= {summary_irq_flag_r, 2'b00, uf_r, 4'h0};
      else if (idx_r == `RTCU_IDX_D)
        bus_rdata <= {vrt_r, 7'h00};
      else
        bus_rdata <= ram_r[idx_r];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_upd_end;
    upd_done;
  endsequence
  sequence s_read_valid;
    data_rd && idx_r == `RTCU_IDX_D && !logic_clr;
  endsequence

  osc_gate_a: assert property (!osc_on |-> !tb_tick) else $error("time base ticks with oscillator off");
  chain_hold_a: assert property (osc_hold && !logic_clr |=> chain_cnt == CW'((1 << CW) - START_TICKS))
    else $error("chain not held at half second");
  set_abort_a: assert property (ctl_b_r[`RTCU_B_SET] |-> !upd_done ##1 !update_in_progress_flag) else $error("update while inhibited");
  upd_len_a: assert property (s_upd_end |-> chain_cnt == CW'(UPD_TICKS - 1))
    else $error("update length wrong");
  busy_uip_a: assert property (upd_r == rtcu_pkg::UPD_BUSY |-> update_in_progress_flag) else $error("busy flag low during update");
  uip_lead_a: assert property ($rose(upd_r == rtcu_pkg::UPD_BUSY) |-> $past(chain_cnt) == {CW{1'b1}})
    else $error("update started off the second boundary");
  uf_irq_a: assert property (s_upd_end ##0 ctl_b_r[`RTCU_B_UIE] |=> summary_irq_flag_r && uf_r && irq)
    else $error("update-ended flag not raised");
  vrt_read_a: assert property (s_read_valid |=> vrt_r ##1 (vrt_r || $past(logic_clr)))
    else $error("valid flag not set after read");
  batt_clr_a: assert property (logic_clr |=> !vrt_r && $stable(osc_ctrl_r) && ram_r[`RTCU_IDX_SEC] == 8'h00)
    else $error("battery reset incomplete or touched oscillator code");
endmodule // rtcu_core
`default_nettype wire

//--- include/rtcu_params.svh
// offsets, field positions, reset values and timing figures of the clock core
// assumes inclusion by bare name from the core, chain and bench files
`ifndef RTCU_PARAMS_SVH
`define RTCU_PARAMS_SVH

`define RTCU_IDX_SEC 7'h00
`define RTCU_IDX_MIN 7'h02
`define RTCU_IDX_HOUR 7'h04
`define RTCU_NUM_TIME 7'h0a
`define RTCU_IDX_A 7'h0a
`define RTCU_IDX_B 7'h0b
`define RTCU_IDX_C 7'h0c
`define RTCU_IDX_D 7'h0d
`define RTCU_NUM_BYTES 128
`define RTCU_A_UIP 7
`define RTCU_A_OSC_HI 6
`define RTCU_A_OSC_LO 4
`define RTCU_B_SET 7
`define RTCU_B_UIE 4
`define RTCU_B_DM 2
`define RTCU_C_SUMMARY_IRQ_FLAG 7
`define RTCU_C_UF 4
`define RTCU_D_VRT 7
`define RTCU_OSC_NORMAL 3'h2
`define RTCU_OSC_RESET 3'h2
`define RTCU_UNDEF_BYTE 8'hff
`define RTCU_CLK_HZ 125000000
`define RTCU_TB_HZ 32768
`define RTCU_UPD_US 1984
`define RTCU_LEAD_US 244
`define RTCU_START_MS 500
`define RTCU_CHAIN_W 15

`endif

//--- include/rtcu_pkg.sv
// types shared by the clock core files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package rtcu_pkg;
  typedef logic [7:0] rtcu_byte_t;
  typedef enum logic [1:0] {UPD_IDLE, UPD_PEND, UPD_BUSY} rtcu_upd_e;
endpackage
`default_nettype wire

//--- verilog/rtcu_incr.sv
// one time field stepped by one, binary or bcd, wrapping past a limit
// assumes the field holds a valid value of the selected format
`default_nettype none
module rtcu_incr #(
  parameter int unsigned LIMIT = 59
) (
  input wire rtcu_pkg::rtcu_byte_t value_in,
  input wire logic bcd_mode,
  output rtcu_pkg::rtcu_byte_t value_out,
  output logic carry
);
  localparam logic [7:0] LIM_BIN = 8'(LIMIT);
  localparam logic [7:0] LIM_BCD = 8'(((LIMIT / 10) << 4) | (LIMIT % 10));

  initial
  begin
    if (LIMIT > 99)
      $error("rtcu_incr: limit above 99");
  end

  always_comb
  begin
    carry = value_in >= (bcd_mode ? LIM_BCD : LIM_BIN);
    if (carry)
      value_out = 8'h00;
    else if (bcd_mode && value_in[3:0] >= 4'h9)
      value_out = {value_in[7:4] + 4'h1, 4'h0};
    else
      value_out = value_in + 8'h01;
  end
endmodule // rtcu_incr
`default_nettype wire

//--- verilog/rtcu_chain.sv
// fifteen-stage up-counting chain of the time base, with hold and clear
// assumes adv pulses once per time-base tick
`default_nettype none
`include "rtcu_params.svh"
module rtcu_chain #(
  parameter int unsigned WIDTH = `RTCU_CHAIN_W,
  parameter int unsigned PRELOAD = 16384
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic hold,
  input wire logic adv,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  initial
  begin
    if (WIDTH < 2 || WIDTH > 30 || PRELOAD >= (1 << WIDTH))
      $error("rtcu_chain: bad width or preload");
  end

  assign wrap = adv && !hold && (count == {WIDTH{1'b1}});

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= '0;
    else if (clr || hold)
      count <= WIDTH'(PRELOAD);
    else if (adv)
      count <= count + 1'b1;
  end
endmodule // rtcu_chain
`default_nettype wire

//--- verification/rtcu_core_bench.sv
// self-checking bench of the clock core, driven through the index and data ports
// assumes one base tick per clk when CLK_HZ equals TB_HZ
`default_nettype none
`include "rtcu_params.svh"
module rtcu_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic primary_reset_b = 1'b1;
  logic battery_sense_input = 1'b1;
  logic bus_data_sel = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  rtcu_pkg::rtcu_byte_t bus_wdata = 8'h00;
  rtcu_pkg::rtcu_byte_t bus_rdata;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0 = 0;
  localparam int LIMIT = 60000;
  rtcu_core #(.CLK_HZ(2), .TB_HZ(2)) u_rtcu_core (
    .clk(clk), .rst_b(rst_b), .primary_reset_b(primary_reset_b),
    .battery_sense_input(battery_sense_input), .bus_data_sel(bus_data_sel),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .irq(irq)
  );
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_byte(input string what, input rtcu_pkg::rtcu_byte_t exp, input rtcu_pkg::rtcu_byte_t got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input rtcu_pkg::rtcu_byte_t d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_data_sel <= 1'b0;
    bus_wdata <= idx;
    @(posedge clk);
    bus_data_sel <= 1'b1;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, output rtcu_pkg::rtcu_byte_t d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_data_sel <= 1'b0;
    bus_wdata <= idx;
    @(posedge clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    bus_data_sel <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(posedge clk);
    #1;
    d = bus_rdata;
  endtask
  task automatic wait_to(input int n);
    while (cyc < t0 + n)
      @(posedge clk);
  endtask
  // reset values and the valid flag after a good-battery power-up
  task automatic test_power_up();
    rtcu_pkg::rtcu_byte_t d;
    rd(8'h0a, d);
    chk_byte("control a", 8'h20, d);
    rd(8'h0d, d);
    chk_byte("valid first", 8'h00, d);
    rd(8'h0d, d);
    chk_byte("valid second", 8'h80, d);
  endtask
  // chain held, good and bad battery master resets
  task automatic test_battery();
    rtcu_pkg::rtcu_byte_t d;
    wr(8'h0a, 8'h60);
    wr(8'h0b, 8'h10);
    wr(8'h00, 8'h59);
    wr(8'h02, 8'h00);
    @(posedge clk);
    primary_reset_b <= 1'b0;
    @(posedge clk);
    primary_reset_b <= 1'b1;
    rd(8'h00, d);
    chk_byte("seconds after good reset", 8'h59, d);
    rd(8'h0d, d);
    chk_byte("valid after good reset", 8'h80, d);
    @(posedge clk);
    primary_reset_b <= 1'b0;
    battery_sense_input <= 1'b0;
    @(posedge clk);
    primary_reset_b <= 1'b1;
    @(posedge clk);
    battery_sense_input <= 1'b1;
    rd(8'h0a, d);
    chk_byte("oscillator kept", 8'h60, d);
    rd(8'h00, d);
    chk_byte("seconds cleared", 8'h00, d);
    rd(8'h0d, d);
    chk_byte("valid cleared", 8'h00, d);
    rd(8'h0d, d);
    chk_byte("valid after read", 8'h80, d);
    t0 = cyc;
    wait_to(2000);
    wr(8'h0b, 8'h10);
    wr(8'h00, 8'h59);
    wr(8'h02, 8'h00);
    rd(8'h0a, d);
    chk_byte("held chain idle", 8'h60, d);
  endtask
  // first update half a second after release, then one per second
  task automatic test_updates();
    rtcu_pkg::rtcu_byte_t d;
    wr(8'h0a, 8'h20);
    t0 = cyc - 1;
    wait_to(16364);
    rd(8'h0a, d);
    chk_byte("busy before lead", 8'h20, d);
    rd(8'h00, d);
    chk_byte("seconds after clear flag", 8'h59, d);
    wait_to(16376);
    rd(8'h0a, d);
    chk_byte("busy in lead", 8'ha0, d);
    rd(8'h00, d);
    chk_byte("seconds in lead", 8'h59, d);
    wait_to(16392);
    rd(8'h00, d);
    chk_byte("seconds in update", 8'hff, d);
    rd(8'h0a, d);
    chk_byte("busy in update", 8'ha0, d);
    wait_to(16470);
    chk_bit("irq after update", 1'b1, irq);
    rd(8'h00, d);
    chk_byte("seconds stepped", 8'h00, d);
    rd(8'h02, d);
    chk_byte("minutes carried", 8'h01, d);
    rd(8'h0a, d);
    chk_byte("busy cleared", 8'h20, d);
    rd(8'h0c, d);
    chk_byte("flags", 8'h90, d);
    chk_bit("irq cleared", 1'b0, irq);
    rd(8'h0c, d);
    chk_byte("flags cleared", 8'h00, d);
    wait_to(16364 + 32768);
    rd(8'h0a, d);
    chk_byte("busy before second", 8'h20, d);
    wait_to(16380 + 32768);
    rd(8'h0a, d);
    chk_byte("busy second", 8'ha0, d);
  endtask
  // inhibit aborts the busy update and lets software load time
  task automatic test_inhibit();
    rtcu_pkg::rtcu_byte_t d;
    wr(8'h0b, 8'h90);
    rd(8'h0a, d);
    chk_byte("busy aborted", 8'h20, d);
    repeat (120) @(posedge clk);
    #1;
    chk_bit("no irq inhibited", 1'b0, irq);
    rd(8'h00, d);
    chk_byte("seconds not stepped", 8'h00, d);
    wr(8'h00, 8'h30);
    rd(8'h00, d);
    chk_byte("seconds loaded", 8'h30, d);
    wr(8'h0a, 8'h00);
    wr(8'h0b, 8'h10);
    rd(8'h0a, d);
    chk_byte("oscillator off", 8'h00, d);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    test_power_up();
    test_battery();
    test_updates();
    test_inhibit();
    give_verdict();
  end
endmodule // rtcu_core_bench
`default_nettype wire
